// ---- sci_interrupt_sources.sv ----
// Per-channel interrupt sources: receive, transmit and external/status
`timescale 1ns/1ns
`include "sci_params.svh"

module sci_interrupt_sources
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Configuration
    input wire sci_pkg::sci_rxmode_e rxIntMode,
    input wire sci_pkg::sci_proto_e protoMode,
    input wire logic txIntEnable,
    input wire logic extIntEnable,
    input wire logic globalIntEnable,
    input wire logic [5:0] extSourceEnable,
    // Host commands
    input wire sci_pkg::sci_cmd_s cmd,
    // Receive FIFO side
    input wire logic rxCharPush,
    input wire logic rxFifoHasChar,
    input wire logic rxHeadSpecial,
    input wire logic rxFifoPop,
    // Receive bit stream
    input wire logic rxBitValid,
    input wire logic rxBit,
    input wire logic nullFramingErr,
    // Transmit side
    input wire logic txBufferWrite,
    input wire logic txBufferEmptied,
    input wire logic txCrcDone,
    // External/status sources
    input wire logic underrunEom,
    input wire logic ctsIn,
    input wire logic dcdIn,
    input wire logic syncHuntIn,
    input wire logic zeroCountIn,
    // Outputs
    output sci_pkg::sci_pend_s pendingBits,
    output logic intRequest,
    output logic rxVectorSpecial,
    output logic rxFifoLocked,
    output logic txBufferEmpty,
    output logic [5:0] mainStatus,
    output logic huntForce
);

    // ****************************************************************
    // Break and abort detection
    // ****************************************************************

    logic breakAbort;
    logic huntPulse;

    sci_break_abort breakDet
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .protoMode(protoMode),
        .rxBitValid(rxBitValid),
        .rxBit(rxBit),
        .nullFramingErr(nullFramingErr),
        .breakAbort(breakAbort),
        .huntForce(huntPulse)
    );

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            huntForce <= 1'b0;
        else
            huntForce <= huntPulse;
    end

    // ****************************************************************
    // Receive interrupts
    // ****************************************************************

    sci_pkg::sci_rxmode_e prevMode;
    logic firstArmed;
    logic rxPending;
    logic specialRead;

    // A special character leaving the FIFO raises the interrupt only after
    // it is gone, so status is read from a locked FIFO afterwards.
    assign specialRead = rxFifoPop && rxHeadSpecial;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            prevMode <= sci_pkg::RX_OFF;
        else
            prevMode <= rxIntMode;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            firstArmed <= 1'b0;
        else if (rxIntMode != sci_pkg::RX_FIRST)
            firstArmed <= 1'b0;
        else if (prevMode != sci_pkg::RX_FIRST || cmd.rearmNextChar)
            firstArmed <= 1'b1;
        else if (rxCharPush || rxFifoHasChar)
            firstArmed <= 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rxFifoLocked <= 1'b0;
        else if (rxIntMode == sci_pkg::RX_FIRST || rxIntMode == sci_pkg::RX_SPECIAL)
        begin
            if (specialRead)
                rxFifoLocked <= 1'b1;
            else if (cmd.errorReset)
                rxFifoLocked <= 1'b0;
        end
        else
            rxFifoLocked <= 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rxPending <= 1'b0;
            rxVectorSpecial <= 1'b0;
        end
        else
        begin
            unique case (rxIntMode)
                sci_pkg::RX_OFF:
                begin
                    rxPending <= 1'b0;
                    rxVectorSpecial <= 1'b0;
                end

                sci_pkg::RX_FIRST:
                begin
                    // Both causes share one pending flag
                    if (specialRead)
                    begin
                        rxPending <= 1'b1;
                        rxVectorSpecial <= 1'b1;
                    end
                    else if (firstArmed && (rxCharPush || rxFifoHasChar))
                    begin
                        rxPending <= 1'b1;
                        rxVectorSpecial <= 1'b0;
                    end
                    else if (rxFifoPop && !rxVectorSpecial)
                        rxPending <= 1'b0;
                    else if (cmd.errorReset && rxVectorSpecial)
                    begin
                        rxPending <= 1'b0;
                        rxVectorSpecial <= 1'b0;
                    end
                end

                sci_pkg::RX_ALL:
                begin
                    // Pop clears; a further held character sets it again next cycle
                    if (rxFifoPop)
                        rxPending <= 1'b0;
                    else if (rxFifoHasChar || rxCharPush)
                        rxPending <= 1'b1;
                    rxVectorSpecial <= rxHeadSpecial;
                end

                sci_pkg::RX_SPECIAL:
                begin
                    if (specialRead)
                    begin
                        rxPending <= 1'b1;
                        rxVectorSpecial <= 1'b1;
                    end
                    else if (cmd.errorReset)
                    begin
                        rxPending <= 1'b0;
                        rxVectorSpecial <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Transmit interrupts
    // ****************************************************************

    logic txPending;

    // End of CRC never sets this bit
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            txBufferEmpty <= 1'b1;
        else if (txBufferEmptied)
            txBufferEmpty <= 1'b1;
        else if (txBufferWrite)
            txBufferEmpty <= 1'b0;
    end

    // Set wins over a clear landing in the same cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            txPending <= 1'b0;
        else if (txIntEnable && txBufferEmptied)
            txPending <= 1'b1;
        else if (txIntEnable && txCrcDone && protoMode != sci_pkg::PR_ASYNC)
            txPending <= 1'b1;
        else if (txBufferWrite || cmd.resetTxPending || !txIntEnable)
            txPending <= 1'b0;
    end

    // ****************************************************************
    // External/status interrupts
    // ****************************************************************

    logic [5:0] srcLive;
    logic [5:0] srcPrev;
    logic [5:0] srcHeld;
    logic [5:0] srcRise;
    logic [5:0] srcFall;
    logic [5:0] closeCause;

    logic latchClosed;
    logic closeNow;
    logic extPending;

    // Sources that are live only while enabled read zero when disabled
    always_comb
    begin
        srcLive = `SCI_SRC_RST;
        srcLive[`SCI_SRC_BRK] = breakAbort;
        srcLive[`SCI_SRC_EOM] = underrunEom;
        srcLive[`SCI_SRC_CTS] = ctsIn;
        srcLive[`SCI_SRC_DCD] = dcdIn;
        srcLive[`SCI_SRC_SYN] = syncHuntIn;
        srcLive[`SCI_SRC_ZC] = zeroCountIn && extSourceEnable[`SCI_SRC_ZC];
    end

    assign srcRise = srcLive & ~srcPrev;
    assign srcFall = ~srcLive & srcPrev;

    // Underrun and zero count close only on their rising edge
    genvar g;
    generate
        for (g = 0; g < `SCI_NUM_SRC; g = g + 1)
        begin : causeGen
            if (g == `SCI_SRC_EOM || g == `SCI_SRC_ZC)
            begin : riseOnly
                assign closeCause[g] = extSourceEnable[g] && srcRise[g];
            end
            else
            begin : bothEdges
                assign closeCause[g] = extSourceEnable[g] && (srcRise[g] || srcFall[g]);
            end
        end
    endgenerate

    assign closeNow = |closeCause;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            srcPrev <= `SCI_SRC_RST;
        else
            srcPrev <= srcLive;
    end

    // Reopen loses to a closing event in the same cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            latchClosed <= 1'b0;
        else if (closeNow && !latchClosed)
            latchClosed <= 1'b1;
        else if (cmd.resetExtStatus && !closeNow)
            latchClosed <= 1'b0;
    end

    // Held values follow the sources while open and freeze on closure;
    // a break/abort edge updates its bit even while closed so it is caught.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            srcHeld <= `SCI_SRC_RST;
        else if (!latchClosed)
            srcHeld <= srcLive;
        else if (closeCause[`SCI_SRC_BRK])
            srcHeld[`SCI_SRC_BRK] <= srcLive[`SCI_SRC_BRK];
    end

    // Pending follows the latch state, so reopening drops it
    // in the same cycle as the reset command
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            extPending <= 1'b0;
        else if (extIntEnable && (closeNow || (latchClosed && !cmd.resetExtStatus)))
            extPending <= 1'b1;
        else
            extPending <= 1'b0;
    end

    // Status shows held values only for enabled sources with closed latches
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            mainStatus <= `SCI_SRC_RST;
        else if (latchClosed)
            mainStatus <= (srcHeld & extSourceEnable) | (srcLive & ~extSourceEnable);
        else
            mainStatus <= srcLive;
    end

    // ****************************************************************
    // Request and polled pending bits
    // ****************************************************************

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            pendingBits <= '0;
        else
        begin
            pendingBits.rx <= rxPending;
            pendingBits.tx <= txPending;
            pendingBits.ext <= extPending;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            intRequest <= 1'b0;
        else
            intRequest <= globalIntEnable && (rxPending || txPending || extPending);
    end

endmodule

// ---- sci_params.svh ----
// Constants for the serial channel interrupt source block
//
// Contract
// - Two-bit receive mode: disabled, first char, all chars, special only.
// - First-char mode: first arriving or already held character sets receive pending.
// - Global interrupt enable low blocks every interrupt request.
// - First-char and special interrupts share pending; only vector status differs.
// - All-chars mode: every character sets receive pending, held ones too.
// - All-chars mode: receive pending clears when the character is popped.
// - All-chars mode: special condition never locks the FIFO.
// - Special-only mode: only special characters set receive pending.
// - Special-only mode: interrupt waits until the special character is read.
// - Special condition locks FIFO until the error reset command.
// - Transmit interrupt enable bit; buffer-empty status still pollable.
// - Transmit pending sets on each full-to-empty buffer transition.
// - Sync modes: end of CRC sets transmit pending, not buffer-empty.
// - Transmit pending clears on buffer write or reset command.
// - Pending bits stay readable with global enable cleared.
// - External/status master enable plus one enable per source.
// - Six sources: break/abort, underrun, CTS, carrier, sync/hunt, zero count.
// - Disabled source: no latch, live status, never interrupts; the code reads zero count as zero while it is disabled.
// - Any enabled source change closes all enabled latches together; underrun and zero count close only on their rising edge.
// - Latch closure sets pending; reset command reopens latches.
// - Master enable clear: pending never set, latches still work.
// - Break/abort only in async and SDLC; zero elsewhere.
// - Async break: null with framing error, holds on zeros, ends on one.
// - SDLC abort: seven ones set, zero clears, forces hunt.
// - Both break/abort edges close the latches while break/abort is enabled.
`ifndef SCI_PARAMS_SVH
`define SCI_PARAMS_SVH

`define SCI_ABORT_ONES 3'h7
`define SCI_SRC_BRK 0
`define SCI_SRC_EOM 1
`define SCI_SRC_CTS 2
`define SCI_SRC_DCD 3
`define SCI_SRC_SYN 4
`define SCI_SRC_ZC 5
`define SCI_NUM_SRC 6
`define SCI_SRC_RST 6'h00

`endif

// ---- sci_pkg.sv ----
// Types shared by the serial channel interrupt source block
package sci_pkg;

    typedef enum logic [1:0]
    {
        RX_OFF = 2'b00,
        RX_FIRST = 2'b01,
        RX_ALL = 2'b10,
        RX_SPECIAL = 2'b11
    } sci_rxmode_e;

    typedef enum logic [1:0]
    {
        PR_ASYNC = 2'b00,
        PR_SDLC = 2'b01,
        PR_SYNC = 2'b10,
        PR_EXTSYNC = 2'b11
    } sci_proto_e;

    // Host command strobes, one cycle each
    typedef struct packed
    {
        logic rearmNextChar;
        logic errorReset;
        logic resetTxPending;
        logic resetExtStatus;
    } sci_cmd_s;

    // Pending bits as polled by the host
    typedef struct packed
    {
        logic ext;
        logic tx;
        logic rx;
    } sci_pend_s;

endpackage

// ---- sci_break_abort.sv ----
// Break and abort detector on the received bit stream
`timescale 1ns/1ns
`include "sci_params.svh"

module sci_break_abort
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Receiver
    input wire sci_pkg::sci_proto_e protoMode,
    input wire logic rxBitValid,
    input wire logic rxBit,
    input wire logic nullFramingErr,
    // Status
    output logic breakAbort,
    output logic huntForce
);

    logic [2:0] onesCount;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            onesCount <= 3'h0;
        else if (rxBitValid)
        begin
            if (!rxBit)
                onesCount <= 3'h0;
            else if (onesCount != `SCI_ABORT_ONES)
                onesCount <= onesCount + 3'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            breakAbort <= 1'b0;
            huntForce <= 1'b0;
        end
        else
        begin
            huntForce <= 1'b0;
            unique case (protoMode)
                sci_pkg::PR_ASYNC:
                begin
                    if (nullFramingErr)
                        breakAbort <= 1'b1;
                    else if (rxBitValid && rxBit)
                        breakAbort <= 1'b0;
                end
                sci_pkg::PR_SDLC:
                begin
                    if (rxBitValid && rxBit && onesCount == `SCI_ABORT_ONES - 3'h1)
                    begin
                        breakAbort <= 1'b1;
                        huntForce <= !breakAbort;
                    end
                    else if (rxBitValid && !rxBit)
                        breakAbort <= 1'b0;
                end
                sci_pkg::PR_SYNC, sci_pkg::PR_EXTSYNC:
                    breakAbort <= 1'b0;
            endcase
        end
    end

endmodule

// ---- sci_host_model.sv ----
// Host processor model: command strobes and receive character reads
`timescale 1ns/1ns

module sci_host_model
(
    // Clock
    input wire logic clk_sys,
    // Host side of the channel
    output sci_pkg::sci_cmd_s cmd,
    output logic rxFifoPop
);
    initial
    begin
        cmd = '0;
        rxFifoPop = 1'h0;
    end

    // Called just after a rising edge; k is 0 ext reset, 1 tx reset, 2 error reset, 3 rearm
    // Rearm after an end of frame and error reset after the status read stay with the caller
    task automatic issue(input int k);
        cmd <= 4'h1 << k;
        @(posedge clk_sys);
        cmd <= '0;
    endtask

    // Pops one character; a special character's status is read afterwards from the locked FIFO
    task automatic read_char;
        rxFifoPop <= 1'h1;
        @(posedge clk_sys);
        rxFifoPop <= 1'h0;
    endtask
endmodule

// ---- sci_interrupt_sources_asserts.sv ----
// Port checker for the interrupt source block
`timescale 1ns/1ns

module sci_interrupt_sources_asserts
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Watched ports
    input wire sci_pkg::sci_rxmode_e rxIntMode,
    input wire sci_pkg::sci_proto_e protoMode,
    input wire logic txIntEnable,
    input wire logic extIntEnable,
    input wire logic globalIntEnable,
    input wire logic [5:0] extSourceEnable,
    input wire sci_pkg::sci_cmd_s cmd,
    input wire logic rxFifoPop,
    input wire logic rxHeadSpecial,
    input wire logic txBufferEmptied,
    input wire logic txBufferWrite,
    input wire logic ctsIn,
    input wire sci_pkg::sci_pend_s pendingBits,
    input wire logic intRequest,
    input wire logic rxFifoLocked,
    input wire logic [5:0] mainStatus,
    input wire logic huntForce
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_txSet;
        txIntEnable && txBufferEmptied && !txBufferWrite && !cmd.resetTxPending
            |-> ##[1:2] pendingBits.tx;
    endproperty
    a_txSet: assert property (p_txSet) else $error("tx pending not set");

    property p_txOff;
        !txIntEnable [*2] |=> !pendingBits.tx;
    endproperty
    a_txOff: assert property (p_txOff) else $error("tx pending while off");

    property p_global;
        !globalIntEnable [*2] |=> !intRequest;
    endproperty
    a_global: assert property (p_global) else $error("request while blocked");

    property p_rxOff;
        rxIntMode == sci_pkg::RX_OFF [*3] |=> !pendingBits.rx;
    endproperty
    a_rxOff: assert property (p_rxOff) else $error("rx pending while off");

    property p_allNoLock;
        rxIntMode == sci_pkg::RX_ALL [*2] |=> !rxFifoLocked;
    endproperty
    a_allNoLock: assert property (p_allNoLock) else $error("lock in all mode");

    property p_lock;
        rxIntMode == sci_pkg::RX_SPECIAL && rxFifoPop && rxHeadSpecial && !cmd.errorReset
            |-> ##[1:2] (rxFifoLocked && pendingBits.rx);
    endproperty
    a_lock: assert property (p_lock) else $error("special pop did not lock");

    property p_brkSync;
        protoMode inside {sci_pkg::PR_SYNC, sci_pkg::PR_EXTSYNC} [*2] |=> !mainStatus[0];
    endproperty
    a_brkSync: assert property (p_brkSync) else $error("break bit in sync");

    property p_huntPulse;
        huntForce |=> !huntForce;
    endproperty
    a_huntPulse: assert property (p_huntPulse) else $error("hunt pulse too long");

    property p_extClose;
        extIntEnable && extSourceEnable[2] && $changed(ctsIn) && !cmd.resetExtStatus
            |-> ##[1:3] pendingBits.ext;
    endproperty
    a_extClose: assert property (p_extClose) else $error("ext pending not set");

    property p_extHold;
        pendingBits.ext && extIntEnable && $past(extIntEnable) && !cmd.resetExtStatus
            && !$past(cmd.resetExtStatus) |=> pendingBits.ext;
    endproperty
    a_extHold: assert property (p_extHold) else $error("ext pending dropped");
endmodule

bind sci_interrupt_sources sci_interrupt_sources_asserts sci_interrupt_sources_asserts_i
(
    .clk_sys(clk_sys), .rst(rst), .rxIntMode(rxIntMode), .protoMode(protoMode),
    .txIntEnable(txIntEnable), .extIntEnable(extIntEnable),
    .globalIntEnable(globalIntEnable), .extSourceEnable(extSourceEnable), .cmd(cmd),
    .rxFifoPop(rxFifoPop), .rxHeadSpecial(rxHeadSpecial), .txBufferEmptied(txBufferEmptied),
    .txBufferWrite(txBufferWrite), .ctsIn(ctsIn), .pendingBits(pendingBits),
    .intRequest(intRequest), .rxFifoLocked(rxFifoLocked), .mainStatus(mainStatus),
    .huntForce(huntForce)
);

// ---- serial_channel_interrupt_sources_tb_top.sv ----
// Self-checking testbench for the interrupt source block
`timescale 1ns/1ns

`define CHK(a, b) \
    begin \
        n_compared++; \
        if ((a) !== (b)) \
        begin \
            num_errors++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
        end \
    end

module serial_channel_interrupt_sources_tb_top;
    logic clk_sys;
    logic rst;
    sci_pkg::sci_rxmode_e rxIntMode;
    sci_pkg::sci_proto_e protoMode;
    logic txIntEnable, extIntEnable, globalIntEnable;
    logic [5:0] extSourceEnable;
    sci_pkg::sci_cmd_s cmd;
    logic rxCharPush, rxFifoHasChar, rxHeadSpecial, rxFifoPop, rxBitValid, rxBit;
    logic nullFramingErr, txBufferWrite, txBufferEmptied, txCrcDone;
    logic [5:1] extSrc;
    sci_pkg::sci_pend_s pendingBits;
    logic intRequest, rxVectorSpecial, rxFifoLocked, txBufferEmpty, huntForce;
    logic [5:0] mainStatus;
    int num_errors = 0;
    int n_compared = 0;
    int huntSeen = 0;

    sci_interrupt_sources sci_interrupt_sources_i
    (
        .clk_sys(clk_sys), .rst(rst), .rxIntMode(rxIntMode), .protoMode(protoMode),
        .txIntEnable(txIntEnable), .extIntEnable(extIntEnable),
        .globalIntEnable(globalIntEnable), .extSourceEnable(extSourceEnable), .cmd(cmd),
        .rxCharPush(rxCharPush), .rxFifoHasChar(rxFifoHasChar), .rxHeadSpecial(rxHeadSpecial),
        .rxFifoPop(rxFifoPop), .rxBitValid(rxBitValid), .rxBit(rxBit),
        .nullFramingErr(nullFramingErr), .txBufferWrite(txBufferWrite),
        .txBufferEmptied(txBufferEmptied), .txCrcDone(txCrcDone), .underrunEom(extSrc[1]),
        .ctsIn(extSrc[2]), .dcdIn(extSrc[3]), .syncHuntIn(extSrc[4]), .zeroCountIn(extSrc[5]),
        .pendingBits(pendingBits), .intRequest(intRequest), .rxVectorSpecial(rxVectorSpecial),
        .rxFifoLocked(rxFifoLocked), .txBufferEmpty(txBufferEmpty), .mainStatus(mainStatus),
        .huntForce(huntForce)
    );

    sci_host_model sci_host_model_i
    (
        .clk_sys(clk_sys), .cmd(cmd), .rxFifoPop(rxFifoPop)
    );

    // ********
    // Clock and helpers
    // ********
    initial
    begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
        if (huntForce === 1'h1)
            huntSeen++;

    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic go;
        @(posedge clk_sys);
        {txBufferEmptied, txBufferWrite, txCrcDone, rxCharPush, nullFramingErr} <= '0;
        settle;
    endtask

    // Event pulse: 0 emptied, 1 write, 2 crc done, 3 push, 4 null with framing error
    task automatic ev(input int k);
        @(posedge clk_sys);
        case (k)
            0: txBufferEmptied <= 1'h1;
            1: txBufferWrite <= 1'h1;
            2: txCrcDone <= 1'h1;
            3: rxCharPush <= 1'h1;
            default: nullFramingErr <= 1'h1;
        endcase
        go;
    endtask

    task automatic cfg(input logic [1:0] m, p, input logic t, e, g, input logic [5:0] s);
        @(posedge clk_sys);
        rxIntMode <= sci_pkg::sci_rxmode_e'(m);
        protoMode <= sci_pkg::sci_proto_e'(p);
        {txIntEnable, extIntEnable, globalIntEnable, extSourceEnable} <= {t, e, g, s};
        go;
    endtask

    task automatic command(input int k);
        @(posedge clk_sys);
        sci_host_model_i.issue(k);
        settle;
    endtask

    // FIFO view changes on the same edge as the host's pop
    task automatic pop(input logic h, s);
        @(posedge clk_sys);
        {rxFifoHasChar, rxHeadSpecial} <= {h, s};
        sci_host_model_i.read_char;
        settle;
    endtask

    task automatic rxq(input logic h, s);
        @(posedge clk_sys);
        {rxFifoHasChar, rxHeadSpecial} <= {h, s};
    endtask

    task automatic src(input int i, input logic v);
        @(posedge clk_sys);
        extSrc[i] <= v;
        go;
    endtask

    task automatic bits(input int n, input logic v);
        repeat (n)
        begin
            @(posedge clk_sys);
            rxBitValid <= 1'h1;
            rxBit <= v;
        end
        @(posedge clk_sys);
        rxBitValid <= 1'h0;
        settle;
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Run is a few hundred cycles; this timeout is 50000 cycles
    initial
    begin
        #1000000;
        num_errors++;
        print_verdict;
    end

    // ********
    // Tests
    // ********
    initial
    begin
        rst = 1'h1;
        rxIntMode = sci_pkg::RX_OFF;
        protoMode = sci_pkg::PR_ASYNC;
        {txIntEnable, extIntEnable, globalIntEnable, extSourceEnable} = '0;
        {rxCharPush, rxFifoHasChar, rxHeadSpecial, rxBitValid, rxBit, nullFramingErr} = '0;
        {txBufferWrite, txBufferEmptied, txCrcDone, extSrc} = '0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        settle;
        `CHK(pendingBits, 3'h0)
        `CHK(txBufferEmpty, 1'h1)
        $display("test reset done");
        cfg(2'h0, 2'h0, 1'h1, 1'h0, 1'h0, 6'h00);
        `CHK(pendingBits.tx, 1'h0)
        ev(0);
        `CHK(pendingBits.tx, 1'h1)
        `CHK(intRequest, 1'h0)
        cfg(2'h0, 2'h0, 1'h1, 1'h0, 1'h1, 6'h00);
        `CHK(intRequest, 1'h1)
        command(1);
        `CHK(pendingBits.tx, 1'h0)
        ev(0);
        ev(1);
        `CHK(pendingBits.tx, 1'h0)
        cfg(2'h0, 2'h2, 1'h1, 1'h0, 1'h1, 6'h00);
        ev(2);
        `CHK(pendingBits.tx, 1'h1)
        `CHK(txBufferEmpty, 1'h0)
        command(1);
        cfg(2'h0, 2'h0, 1'h1, 1'h0, 1'h1, 6'h00);
        ev(2);
        `CHK(pendingBits.tx, 1'h0)
        cfg(2'h0, 2'h0, 1'h0, 1'h0, 1'h1, 6'h00);
        ev(0);
        `CHK(pendingBits.tx, 1'h0)
        `CHK(txBufferEmpty, 1'h1)
        $display("test transmit done");
        rxq(1'h1, 1'h0);
        cfg(2'h2, 2'h0, 1'h0, 1'h0, 1'h1, 6'h00);
        `CHK(pendingBits.rx, 1'h1)
        pop(1'h0, 1'h0);
        `CHK(pendingBits.rx, 1'h0)
        rxq(1'h1, 1'h1);
        ev(3);
        `CHK(pendingBits.rx, 1'h1)
        pop(1'h0, 1'h1);
        `CHK(rxFifoLocked, 1'h0)
        cfg(2'h3, 2'h0, 1'h0, 1'h0, 1'h1, 6'h00);
        rxq(1'h1, 1'h0);
        ev(3);
        `CHK(pendingBits.rx, 1'h0)
        rxq(1'h1, 1'h1);
        ev(3);
        `CHK(pendingBits.rx, 1'h0)
        pop(1'h0, 1'h1);
        `CHK(pendingBits.rx, 1'h1)
        `CHK(rxFifoLocked, 1'h1)
        `CHK(rxVectorSpecial, 1'h1)
        rxq(1'h0, 1'h0);
        command(2);
        `CHK(rxFifoLocked, 1'h0)
        rxq(1'h1, 1'h0);
        cfg(2'h1, 2'h0, 1'h0, 1'h0, 1'h1, 6'h00);
        `CHK(pendingBits.rx, 1'h1)
        `CHK(rxVectorSpecial, 1'h0)
        pop(1'h0, 1'h0);
        rxq(1'h1, 1'h0);
        ev(3);
        `CHK(pendingBits.rx, 1'h0)
        pop(1'h0, 1'h0);
        command(3);
        rxq(1'h1, 1'h0);
        ev(3);
        `CHK(pendingBits.rx, 1'h1)
        pop(1'h0, 1'h0);
        cfg(2'h0, 2'h0, 1'h0, 1'h0, 1'h1, 6'h00);
        rxq(1'h1, 1'h0);
        ev(3);
        `CHK(pendingBits.rx, 1'h0)
        rxq(1'h0, 1'h0);
        $display("test receive done");
        cfg(2'h0, 2'h0, 1'h0, 1'h1, 1'h1, 6'h05);
        command(0);
        src(2, 1'h1);
        `CHK(pendingBits.ext, 1'h1)
        src(2, 1'h0);
        `CHK(mainStatus[2], 1'h1)
        src(3, 1'h1);
        `CHK(mainStatus[3], 1'h1)
        command(0);
        `CHK(pendingBits.ext, 1'h0)
        src(3, 1'h0);
        `CHK(pendingBits.ext, 1'h0)
        cfg(2'h0, 2'h0, 1'h0, 1'h0, 1'h1, 6'h05);
        src(2, 1'h1);
        src(2, 1'h0);
        `CHK(pendingBits.ext, 1'h0)
        `CHK(mainStatus[2], 1'h1)
        for (int i = 1; i < 6; i++)
        begin
            cfg(2'h0, 2'h0, 1'h0, 1'h1, 1'h1, 6'h01 << i);
            command(0);
            src(i, 1'h1);
            `CHK(pendingBits.ext, 1'h1)
            `CHK(mainStatus[i], 1'h1)
            src(i, 1'h0);
            command(0);
        end
        $display("test external done");
        cfg(2'h0, 2'h1, 1'h0, 1'h1, 1'h1, 6'h01);
        command(0);
        bits(6, 1'h1);
        `CHK(mainStatus[0], 1'h0)
        bits(1, 1'h1);
        `CHK(mainStatus[0], 1'h1)
        `CHK(huntSeen, 1)
        bits(1, 1'h0);
        `CHK(mainStatus[0], 1'h0)
        command(0);
        cfg(2'h0, 2'h0, 1'h0, 1'h1, 1'h1, 6'h01);
        ev(4);
        `CHK(mainStatus[0], 1'h1)
        bits(3, 1'h0);
        `CHK(mainStatus[0], 1'h1)
        bits(1, 1'h1);
        `CHK(mainStatus[0], 1'h0)
        command(0);
        cfg(2'h0, 2'h2, 1'h0, 1'h1, 1'h1, 6'h01);
        ev(4);
        `CHK(mainStatus[0], 1'h0)
        $display("test break done");
        print_verdict;
    end
endmodule
